// File: shared/ufp_pkg.sv
// Constants and types for the parallel FIFO port
package ufp_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RX_DEPTH = 16;
  localparam int unsigned TX_DEPTH = 16;
  localparam int unsigned PTR_W = 4;
  localparam int unsigned CNT_W = 5;
  // Transmit timeout in ms, default and least legal value
  localparam logic [7:0] TX_TIMEOUT_MS_RST = 8'h10;
  localparam logic [7:0] TX_TIMEOUT_MS_MIN = 8'h01;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  // Least wake pulse on the receive-flag pin
  localparam int unsigned WAKE_MS = 20;
  localparam int unsigned WAKE_CYCLES = (CLK_HZ / 1000) * WAKE_MS;
  localparam int unsigned MS_W = 15;
  localparam int unsigned WAKE_W = 20;
  typedef enum logic [1:0] {UFP_UNCONF, UFP_NORMAL, UFP_SUSPEND} ufp_pwr_t;
endpackage

// File: core/ufp_fifo.sv
// Small synchronous byte FIFO with occupancy count
`timescale 1ns/1ps
module ufp_fifo
  import ufp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic push,
  input wire logic [DATA_W-1:0] push_data,
  input wire logic pop,
  output logic [DATA_W-1:0] head,
  output logic [CNT_W-1:0] count
);
  typedef struct packed {
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [CNT_W-1:0] cnt;
  } ufp_fifo_st_t;
  ufp_fifo_st_t s_q;
  ufp_fifo_st_t s_d;
  logic [DATA_W-1:0] mem_q [RX_DEPTH];
  logic do_push;
  logic do_pop;

  // Overflow and underflow requests are dropped rather than corrupting pointers
  assign do_push = push && (s_q.cnt != CNT_W'(RX_DEPTH));
  assign do_pop = pop && (s_q.cnt != '0);
  assign head = mem_q[s_q.rd];
  assign count = s_q.cnt;

  always_comb
  begin
    s_d = s_q;
    if (do_push)
    begin
      s_d.wr = s_q.wr + 4'h1;
    end
    if (do_pop)
    begin
      s_d.rd = s_q.rd + 4'h1;
    end
    s_d.cnt = s_q.cnt + CNT_W'(do_push) - CNT_W'(do_pop);
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (do_push)
    begin
      mem_q[s_q.wr] <= push_data;
    end
  end
endmodule // ufp_fifo

// File: core/ufp_port.sv
// Byte-wide parallel FIFO port between USB engine and target logic
`timescale 1ns/1ps
module ufp_port
  import ufp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  // Target-side pins
  input wire logic [DATA_W-1:0] fifo_data_in,
  output logic [DATA_W-1:0] fifo_data_out,
  output logic fifo_data_oe,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic tx_space_n,
  output logic tx_space_oe,
  input wire logic rx_avail_in,
  output logic rx_avail_n,
  output logic rx_avail_oe,
  output logic power_enable_n,
  input wire logic flush_wake_n,
  // USB engine side
  input wire logic usb_configured,
  input wire logic usb_suspend,
  input wire logic remote_wake_en,
  input wire logic [7:0] tx_timeout_ms,
  input wire logic rx_valid,
  input wire logic [DATA_W-1:0] rx_data,
  output logic rx_ready,
  input wire logic bulk_in_req,
  output logic tx_valid,
  output logic [DATA_W-1:0] tx_data,
  input wire logic tx_ready,
  output logic tx_flush,
  output logic resume_req
);
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic fw_n;
    logic flush_pend;
    logic sending;
    logic [7:0] ms_cnt;
    logic [MS_W-1:0] tick;
    logic [WAKE_W-1:0] wake_cnt;
    logic oe_out;
    logic rxf_n;
    logic rxf_oe;
    logic txe_n;
    logic txe_oe;
    logic pwr_n;
    logic resume;
    logic flush;
    logic rx_rdy;
    logic [DATA_W-1:0] dout;
  } ufp_st_t;
  ufp_st_t s_q;
  ufp_st_t s_d;
  logic [DATA_W-1:0] rx_head;
  logic [CNT_W-1:0] rx_cnt;
  logic [DATA_W-1:0] tx_head;
  logic [CNT_W-1:0] tx_cnt;
  logic rx_pop;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic awake;
  logic wake_mode;
  logic [7:0] tmo;

  assign awake = usb_configured && !usb_suspend;
  assign wake_mode = usb_suspend && remote_wake_en;
  // Out-of-range zero is treated as the least legal timeout
  assign tmo = (tx_timeout_ms < TX_TIMEOUT_MS_MIN) ? TX_TIMEOUT_MS_MIN : tx_timeout_ms;
  assign rx_pop = s_q.oe_out && !s_q.rd_n && rd_n;
  assign tx_push = s_q.wr_n && !wr_n;
  assign rx_push = rx_valid && s_q.rx_rdy;
  assign tx_pop = s_q.sending && tx_ready && (tx_cnt != '0);

  ufp_fifo u_rx (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .push(rx_push),
    .push_data(rx_data),
    .pop(rx_pop),
    .head(rx_head),
    .count(rx_cnt)
  );

  ufp_fifo u_tx (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .push(tx_push),
    .push_data(fifo_data_in),
    .pop(tx_pop),
    .head(tx_head),
    .count(tx_cnt)
  );

  always_comb
  begin
    s_d = s_q;
    s_d.rd_n = rd_n;
    s_d.wr_n = wr_n;
    s_d.fw_n = flush_wake_n;
    s_d.flush = 1'b0;
    s_d.resume = 1'b0;
    s_d.pwr_n = !awake;
    // Read strobe drives the head byte latched at its fall; engine data arriving mid-read is still accepted
    s_d.oe_out = !rd_n;
    if (!rd_n && s_q.rd_n)
    begin
      s_d.dout = rx_head;
    end
    if (rd_n)
    begin
      s_d.oe_out = 1'b0;
    end
    s_d.rx_rdy = (rx_cnt < CNT_W'(RX_DEPTH - 1)) && awake;
    // Flags: receive flag counts the pending pop so it never shows a stale byte
    s_d.rxf_n = (rx_cnt == '0) || ((rx_cnt == CNT_W'(1)) && rx_pop);
    s_d.rxf_oe = !(wake_mode && s_q.pwr_n);
    s_d.txe_n = (tx_cnt >= CNT_W'(TX_DEPTH - 1)) && !(tx_pop && !tx_push);
    s_d.txe_oe = 1'b1;
    // Send-immediate and timeout flush
    if (s_q.fw_n && !flush_wake_n && !s_q.pwr_n)
    begin
      s_d.flush_pend = 1'b1;
    end
    if (tx_cnt == '0)
    begin
      s_d.ms_cnt = '0;
      s_d.tick = '0;
    end
    else if (!s_q.sending)
    begin
      if (s_q.tick == MS_W'(MS_CYCLES - 1))
      begin
        s_d.tick = '0;
        s_d.ms_cnt = s_q.ms_cnt + 8'h01;
        if (s_q.ms_cnt + 8'h01 >= tmo)
        begin
          s_d.flush_pend = 1'b1;
        end
      end
      else
      begin
        s_d.tick = s_q.tick + MS_W'(1);
      end
    end
    if (bulk_in_req && !s_q.sending && (tx_cnt != '0) && (s_d.flush_pend || s_q.flush_pend
        || tx_cnt >= CNT_W'(TX_DEPTH - 1)))
    begin
      s_d.sending = 1'b1;
      s_d.flush = 1'b1;
      s_d.flush_pend = 1'b0;
      s_d.ms_cnt = '0;
      s_d.tick = '0;
    end
    if (s_q.sending && (tx_cnt == '0 || (tx_cnt == CNT_W'(1) && tx_pop)))
    begin
      s_d.sending = 1'b0;
    end
    // Remote wakeup: flush strobe, or receive pin held low long enough
    if (wake_mode && s_q.pwr_n)
    begin
      if (s_q.fw_n && !flush_wake_n)
      begin
        s_d.resume = 1'b1;
      end
      if (!rx_avail_in)
      begin
        if (s_q.wake_cnt == WAKE_W'(WAKE_CYCLES - 1))
        begin
          s_d.resume = 1'b1;
        end
        if (s_q.wake_cnt != WAKE_W'(WAKE_CYCLES))
        begin
          s_d.wake_cnt = s_q.wake_cnt + WAKE_W'(1);
        end
      end
      else
      begin
        s_d.wake_cnt = '0;
      end
    end
    else
    begin
      s_d.wake_cnt = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.rd_n <= 1'b1;
      s_q.wr_n <= 1'b1;
      s_q.fw_n <= 1'b1;
      s_q.rxf_n <= 1'b1;
      s_q.txe_n <= 1'b1;
      s_q.pwr_n <= 1'b1;
      // Flags stay undriven until released from reset
      s_q.rxf_oe <= 1'b0;
      s_q.txe_oe <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign fifo_data_out = s_q.dout;
  assign fifo_data_oe = s_q.oe_out;
  assign tx_space_n = s_q.txe_n;
  assign tx_space_oe = s_q.txe_oe;
  assign rx_avail_n = s_q.rxf_n;
  assign rx_avail_oe = s_q.rxf_oe;
  assign power_enable_n = s_q.pwr_n;
  assign rx_ready = s_q.rx_rdy;
  assign tx_flush = s_q.flush;
  assign resume_req = s_q.resume;
  // Transmit head is memory-read; the valid qualifier is registered
  // Sending is only held while bytes remain, so it is the valid flag itself
  assign tx_valid = s_q.sending;
  assign tx_data = tx_head;
endmodule // ufp_port

// File: test/ufp_port_properties.sv
// Port-level checker for the parallel FIFO port
`timescale 1ns/1ps
module ufp_port_chk
  import ufp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic rd_n,
  input wire logic fifo_data_oe,
  input wire logic [DATA_W-1:0] fifo_data_out,
  input wire logic usb_configured,
  input wire logic usb_suspend,
  input wire logic remote_wake_en,
  input wire logic power_enable_n,
  input wire logic flush_wake_n,
  input wire logic resume_req,
  input wire logic rx_avail_oe,
  input wire logic bulk_in_req,
  input wire logic tx_flush
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  rd_drive_a: assert property (!rd_n |=> fifo_data_oe)
    else $error("bus not driven");
  rd_hold_a: assert property (!rd_n [*3] |-> $stable(fifo_data_out))
    else $error("read byte moved");
  rd_release_a: assert property (rd_n |=> !fifo_data_oe)
    else $error("bus not released");
  pwr_on_a: assert property (usb_configured && !usb_suspend |=> !power_enable_n)
    else $error("power enable high");
  pwr_off_a: assert property (!usb_configured || usb_suspend |=> power_enable_n)
    else $error("power enable low");
  wake_req_a: assert property ($fell(flush_wake_n) && usb_suspend && remote_wake_en
    && power_enable_n |=> resume_req)
    else $error("no resume");
  wake_pin_a: assert property (usb_suspend && remote_wake_en && power_enable_n
    |=> !rx_avail_oe)
    else $error("receive pin driven");
  flush_req_a: assert property (tx_flush |-> bulk_in_req || $past(bulk_in_req))
    else $error("send without request");
  cover property (tx_flush);
  cover property (resume_req);
  cover property (!rd_n ##1 fifo_data_oe);
endmodule // ufp_port_chk

bind ufp_port ufp_port_chk ufp_port_chk_inst (.*);

// File: test/ufp_target_model.sv
// Target-side controller model driving the FIFO strobes
`timescale 1ns/1ps
module ufp_target_model
  import ufp_pkg::*;
#(parameter int GAP = 0)
(
  input wire logic sys_clk,
  input wire logic [DATA_W-1:0] bus_in,
  input wire logic tx_space_n,
  input wire logic rx_avail_n,
  output logic [DATA_W-1:0] fifo_data_in,
  output logic rd_n = 1'b1,
  output logic wr_n = 1'b1
);
  initial fifo_data_in = 8'h00;
  task automatic wr(input logic [DATA_W-1:0] b);
    while (tx_space_n)
      @(posedge sys_clk);
    fifo_data_in <= b;
    wr_n <= 1'b0;
    @(posedge sys_clk);
    // Data moves while strobe low, so a late capture is caught
    fifo_data_in <= ~b;
    @(posedge sys_clk);
    wr_n <= 1'b1;
    repeat (2 + GAP) @(posedge sys_clk);
  endtask
  task automatic rd(output logic [DATA_W-1:0] b);
    @(posedge sys_clk);
    while (rx_avail_n)
      @(posedge sys_clk);
    rd_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    b = bus_in;
    rd_n <= 1'b1;
    repeat (2 + GAP) @(posedge sys_clk);
  endtask
endmodule // ufp_target_model

// File: test/tb_top.sv
// Self-checking bench for the parallel FIFO port
`timescale 1ns/1ps
module tb_top;
  import ufp_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [DATA_W-1:0] fifo_data_in, fifo_data_out, tx_data, bus_in, b;
  logic [DATA_W-1:0] rx_data = 8'h00;
  logic fifo_data_oe, rd_n, wr_n, tx_space_n, tx_space_oe, rx_avail_n, rx_avail_oe;
  logic power_enable_n, rx_ready, tx_valid, tx_flush, resume_req, rx_avail_in;
  logic flush_wake_n = 1'b1, usb_configured = 1'b0, usb_suspend = 1'b0, remote_wake_en = 1'b0;
  logic rx_valid = 1'b0, bulk_in_req = 1'b0, tx_ready = 1'b0;
  logic wake_pull_n = 1'b1;
  logic [7:0] tx_timeout_ms = 8'hff;
  int err_count = 0, cmp_count = 0, cyc = 0, t;
  assign bus_in = fifo_data_oe ? fifo_data_out : ~fifo_data_out;
  // Pull-up holds the receive pin unless the controller pulls it low
  assign rx_avail_in = rx_avail_oe ? rx_avail_n : wake_pull_n;
  ufp_port ufp_port_inst (.*);
  ufp_target_model ufp_target_model_inst (.*);
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_count++;
      close_out();
    end
  end
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic drain(input int n, input logic [7:0] base);
    t = 0;
    for (int i = 0; i < n; t++)
    begin
      @(posedge sys_clk);
      if (tx_valid)
      begin
        chk(tx_data, base + i[7:0]);
        i++;
      end
    end
  endtask
  task automatic t_rx();
    @(posedge sys_clk);
    rx_data <= 8'ha0;
    rx_valid <= 1'b1;
    for (int i = 0; i < 3;)
    begin
      @(posedge sys_clk);
      if (rx_ready)
        i++;
      rx_data <= 8'ha0 + i[7:0];
    end
    rx_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk(8'(rx_avail_n), 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      ufp_target_model_inst.rd(b);
      chk(b, 8'ha0 + i[7:0]);
    end
    #1 chk(8'(rx_avail_n), 8'h01);
  endtask
  task automatic t_flush();
    ufp_target_model_inst.wr(8'h30);
    ufp_target_model_inst.wr(8'h31);
    #1 chk(8'(tx_valid), 8'h00);
    @(posedge sys_clk);
    // Strobe stays low while draining; only its falling edge requests the send
    flush_wake_n <= 1'b0;
    drain(2, 8'h30);
    flush_wake_n <= 1'b1;
  endtask
  task automatic t_full();
    bulk_in_req <= 1'b0;
    for (int i = 0; i < 15; i++)
      ufp_target_model_inst.wr(8'h40 + i[7:0]);
    #1 chk(8'(tx_space_n), 8'h01);
    @(posedge sys_clk);
    bulk_in_req <= 1'b1;
    drain(15, 8'h40);
    repeat (2) @(posedge sys_clk);
    #1 chk(8'(tx_space_n), 8'h00);
  endtask
  task automatic t_wake();
    @(posedge sys_clk);
    usb_suspend <= 1'b1;
    remote_wake_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk(8'(rx_avail_oe), 8'h00);
    chk(8'(power_enable_n), 8'h01);
    @(posedge sys_clk);
    flush_wake_n <= 1'b0;
    t = 0;
    repeat (4) @(posedge sys_clk) t += int'(resume_req);
    chk(t[7:0], 8'h01);
    // A full 20 ms hold outlasts this run; a short pull must not wake
    wake_pull_n <= 1'b0;
    t = 0;
    repeat (200) @(posedge sys_clk) t += int'(resume_req);
    wake_pull_n <= 1'b1;
    chk(t[7:0], 8'h00);
  endtask
  initial
  begin
    repeat (5) @(posedge sys_clk);
    chk(8'({tx_space_oe, rx_avail_oe}), 8'h00);
    repeat (15) @(posedge sys_clk);
    resetn <= 1'b1;
    usb_configured <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk(8'(power_enable_n), 8'h00);
    t_rx();
    @(posedge sys_clk);
    bulk_in_req <= 1'b1;
    tx_ready <= 1'b1;
    t_flush();
    t_full();
    @(posedge sys_clk);
    tx_timeout_ms <= 8'h01;
    ufp_target_model_inst.wr(8'h55);
    drain(1, 8'h55);
    chk(8'(t <= 2 * MS_CYCLES), 8'h01);
    chk(8'(t >= MS_CYCLES - 8), 8'h01);
    t_wake();
    close_out();
  end
endmodule // tb_top
